// [rtl/cafct_pkg.sv]
// package: register map, field positions, reset values and rates of the calendar block
package cafct_pkg;

  // clock rates and timing figures
  localparam int unsigned SYS_CLK_HZ = 40_000_000; // system clock rate
  localparam int unsigned XTAL_HZ = 32_768; // modelled low-speed crystal rate
  localparam int unsigned CAL_PRESCALE = 8; // crystal periods per 4096 Hz tick
  localparam int unsigned ALARM_DELAY_XTAL = 8; // crystal periods from match to alarm flag
  localparam int unsigned ACC_W = 26; // phase accumulator width, holds SYS_CLK_HZ
  localparam int unsigned SUB_W = 12; // 4096 Hz ticks per second, as a counter width
  localparam int unsigned SUB64_W = 6; // low sub-second bits that wrap at 64 Hz

  // register indices on the 4-bit address port
  localparam logic [3:0] ADDR_SEC = 4'h0;
  localparam logic [3:0] ADDR_MIN = 4'h1;
  localparam logic [3:0] ADDR_HOUR = 4'h2;
  localparam logic [3:0] ADDR_WEEK = 4'h3;
  localparam logic [3:0] ADDR_DAY = 4'h4;
  localparam logic [3:0] ADDR_MONTH = 4'h5;
  localparam logic [3:0] ADDR_YEAR = 4'h6;
  localparam logic [3:0] ADDR_AL_MIN = 4'h7;
  localparam logic [3:0] ADDR_AL_HOUR = 4'h8;
  localparam logic [3:0] ADDR_AL_WKDY = 4'h9;
  localparam logic [3:0] ADDR_PRESET_LO = 4'hA;
  localparam logic [3:0] ADDR_PRESET_HI = 4'hB;
  localparam logic [3:0] ADDR_CONFIG = 4'hC;
  localparam logic [3:0] ADDR_FLAGS = 4'hD;
  localparam logic [3:0] ADDR_IEN_STOP = 4'hE;

  // implemented bits of each register
  localparam logic [7:0] MASK_SEC = 8'h7F;
  localparam logic [7:0] MASK_HOUR = 8'h3F;
  localparam logic [7:0] MASK_WEEK = 8'h7F;
  localparam logic [7:0] MASK_MONTH = 8'h1F;
  localparam logic [7:0] MASK_AL_HOUR = 8'hBF;
  localparam logic [7:0] MASK_PRESET_HI = 8'h0F;
  localparam logic [7:0] MASK_CONFIG = 8'h73;
  localparam logic [7:0] MASK_FLAGS = 8'h38;
  localparam logic [7:0] MASK_IEN_STOP = 8'h39;

  // field positions
  localparam int unsigned ALARM_IGNORE_BIT = 7; // every_minute/hour/day alarm bits
  localparam int unsigned CFG_TARGET_BIT = 6; // alarm_target_select
  localparam int unsigned CFG_CADENCE_BIT = 5; // update_cadence_select
  localparam int unsigned CFG_RUN_BIT = 4; // cycle_timer_run
  localparam int unsigned CFG_CLKSEL_LSB = 0; // cycle_clock_select, two bits
  localparam int unsigned UPDATE_BIT = 5; // update flag and its enable
  localparam int unsigned CYCLE_BIT = 4; // cycle flag and its enable
  localparam int unsigned ALARM_BIT = 3; // alarm flag and its enable
  localparam int unsigned HALT_BIT = 0; // calendar_halt

  // cycle_clock_select codes
  localparam logic [1:0] SEL_4096HZ = 2'h0;
  localparam logic [1:0] SEL_64HZ = 2'h1;
  localparam logic [1:0] SEL_1HZ = 2'h2;
  localparam logic [1:0] SEL_1PERMIN = 2'h3;

  // reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_WEEK = 8'h01;
  localparam logic [7:0] RST_DAY = 8'h01;
  localparam logic [7:0] RST_MONTH = 8'h01;

  // alarm delay sequencer
  typedef enum logic [0:0] {ALM_IDLE, ALM_WAIT} cafct_alm_state_t;

endpackage

// [rtl/cafct_cycle_timer.sv]
// fixed-cycle countdown timer with selectable source tick and preset reload
module cafct_cycle_timer
  import cafct_pkg::*;
#(
  parameter int unsigned PRESET_W = 12
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // source ticks, one-cycle pulses
  input wire logic tick_4096_i,
  input wire logic tick_64_i,
  input wire logic tick_1_i,
  input wire logic tick_min_i,
  // control
  input wire logic [1:0] clk_sel_i,
  input wire logic run_i,
  input wire logic start_i,
  input wire logic [PRESET_W-1:0] preset_i,
  // expiry pulse
  output logic expire_o
);

  logic [PRESET_W-1:0] count_ff; // remaining source periods
  logic src_tick; // selected source tick
  logic expire_ff; // registered expiry pulse

  // source clock selection
  always_comb begin
    case (clk_sel_i)
      SEL_4096HZ: src_tick = tick_4096_i;
      SEL_64HZ: src_tick = tick_64_i;
      SEL_1HZ: src_tick = tick_1_i;
      SEL_1PERMIN: src_tick = tick_min_i;
      default: src_tick = 1'b0;
    endcase
  end

  // countdown: a start loads the preset, expiry reloads it so the period repeats
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      count_ff <= '0;
      expire_ff <= 1'b0;
    end else begin
      expire_ff <= 1'b0;
      if (start_i) begin
        count_ff <= preset_i;
      end else if (run_i && src_tick) begin
        if (count_ff == PRESET_W'(1)) begin
          count_ff <= preset_i;
          expire_ff <= 1'b1;
        end else if (count_ff == '0) begin
          // preset of zero never expires
          count_ff <= preset_i;
        end else begin
          count_ff <= count_ff - PRESET_W'(1);
        end
      end
    end
  end

  assign expire_o = expire_ff;

  // run low never yields an expiry
  AST_NO_EXPIRE_STOPPED: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    expire_o |-> $past(run_i))
    else $error("cycle timer expired while stopped");

endmodule

// [rtl/cafct_top.sv]
// calendar block: BCD time and date, alarm, time-update and fixed-cycle events
// How it works
// - weekday is one-hot, rotates left daily
// - date BCD counter, never above 31
// - month BCD counter, never above 12
// - year BCD counts 00 to 99, wraps
// - year divisible by four is leap
// - alarm minute bit 7 ignores minutes
// - alarm hour bit 7 ignores hours
// - alarm week/day bit 7 ignores day
// - all enabled fields match sets alarm flag
// - alarm flag raised eight crystal periods later
// - target select: weekday mask or BCD date
// - cadence select: update per second or minute
// - run bit starts countdown, clear stops it
// - cycle source 4096, 64, 1, 1/60 Hz
// - twelve-bit preset split over two registers
// - flags sticky, cleared by writing zero
// - update and cycle events set their flags
// - update enable gates its interrupt
// - cycle events only while cycle enable set
// - alarm events only while alarm enable set
// - halt stops counting, resets sub-second dividers
// - calendar ticks from crystal divided by eight
// - hours 00-23, minutes and seconds 00-59
// - month length with leap February
// - halt suppresses update and alarm events
module cafct_top
  import cafct_pkg::*;
#(
  // crystal model step per system clock; a larger step only shortens a model run
  parameter int unsigned XTAL_STEP = XTAL_HZ
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // register port
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rd_data_o,
  // interrupt request
  output logic irq_o
);

  // bcd increment of a two-digit value
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  // leap when the two-digit year is a multiple of four
  function automatic logic is_leap(input logic [7:0] y);
    if (y[4]) begin
      is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    end else begin
      is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
    end
  endfunction

  // last date of a month, in BCD
  function automatic logic [7:0] last_day(input logic [7:0] m, input logic leap);
    case (m)
      8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
      8'h02: last_day = leap ? 8'h29 : 8'h28;
      default: last_day = 8'h31;
    endcase
  endfunction

  // registers
  logic [7:0] sec_ff, min_ff, hour_ff, week_ff, day_ff, month_ff, year_ff; // time and date
  logic [7:0] al_min_ff, al_hour_ff, al_wkdy_ff; // alarm settings
  logic [7:0] preset_lo_ff, preset_hi_ff; // countdown preset
  logic [7:0] config_ff; // target, cadence, run, source select
  logic [7:0] flags_ff; // sticky event flags
  logic [7:0] nxt_flags; // flags after this cycle
  logic [7:0] ien_stop_ff; // enables and halt
  logic [7:0] rd_data_ff; // read answer

  // dividers
  logic [ACC_W-1:0] acc_ff; // crystal phase accumulator
  logic [ACC_W:0] acc_sum; // accumulator plus one step
  logic xtal_tick; // one pulse per crystal period
  logic [2:0] pre_ff; // crystal to 4096 Hz
  logic [SUB_W-1:0] sub_ff; // 4096 Hz to 1 Hz
  logic tick_4096, tick_64, tick_1; // divided rates
  logic halt; // calendar_halt

  // calendar carries
  logic min_tick, hour_tick, day_tick, month_tick, year_tick;
  logic [7:0] month_end; // last date of the current month

  // alarm
  cafct_alm_state_t alm_state_ff; // delay sequencer
  logic [3:0] alm_dly_ff; // crystal periods waited
  logic alm_fire; // end of the delay
  logic alm_match; // compare result
  logic target_match, min_match, hour_match;

  // events and writes
  logic update_set, cycle_expire, cycle_set, alarm_set;
  logic [7:0] set_vec;
  logic start_pulse; // run bit going high by a write
  logic wr_config, wr_flags;

  assign halt = ien_stop_ff[HALT_BIT];
  assign wr_config = wr_i && (addr_i == ADDR_CONFIG);
  assign wr_flags = wr_i && (addr_i == ADDR_FLAGS);

  // crystal rate model: fractional divider from the system clock, free running
  assign acc_sum = {1'b0, acc_ff} + (ACC_W + 1)'(XTAL_STEP); // step must not exceed SYS_CLK_HZ
  assign xtal_tick = acc_sum >= (ACC_W + 1)'(SYS_CLK_HZ);

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      acc_ff <= '0;
    end else if (xtal_tick) begin
      acc_ff <= ACC_W'(acc_sum - (ACC_W + 1)'(SYS_CLK_HZ));
    end else begin
      acc_ff <= ACC_W'(acc_sum);
    end
  end

  // sub-second chain, held in reset while halted so a restart begins a whole second
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pre_ff <= '0;
      sub_ff <= '0;
    end else if (halt) begin
      pre_ff <= '0;
      sub_ff <= '0;
    end else if (xtal_tick) begin
      pre_ff <= pre_ff + 3'h1;
      if (pre_ff == 3'(CAL_PRESCALE - 1)) begin
        sub_ff <= sub_ff + SUB_W'(1);
      end
    end
  end

  assign tick_4096 = !halt && xtal_tick && (pre_ff == 3'(CAL_PRESCALE - 1));
  assign tick_64 = tick_4096 && (&sub_ff[SUB64_W-1:0]);
  assign tick_1 = tick_4096 && (&sub_ff);

  // carry chain between counters
  assign month_end = last_day(month_ff, is_leap(year_ff));
  assign min_tick = tick_1 && (sec_ff == 8'h59);
  assign hour_tick = min_tick && (min_ff == 8'h59);
  assign day_tick = hour_tick && (hour_ff == 8'h23);
  assign month_tick = day_tick && (day_ff >= month_end);
  assign year_tick = month_tick && (month_ff >= 8'h12);

  // seconds, minutes, hours; a write takes priority over counting
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sec_ff <= RST_ZERO;
      min_ff <= RST_ZERO;
      hour_ff <= RST_ZERO;
    end else begin
      if (wr_i && addr_i == ADDR_SEC) begin
        sec_ff <= wr_data_i & MASK_SEC;
      end else if (tick_1) begin
        sec_ff <= min_tick ? RST_ZERO : bcd_inc(sec_ff);
      end
      if (wr_i && addr_i == ADDR_MIN) begin
        min_ff <= wr_data_i & MASK_SEC;
      end else if (min_tick) begin
        min_ff <= hour_tick ? RST_ZERO : bcd_inc(min_ff);
      end
      if (wr_i && addr_i == ADDR_HOUR) begin
        hour_ff <= wr_data_i & MASK_HOUR;
      end else if (hour_tick) begin
        hour_ff <= day_tick ? RST_ZERO : bcd_inc(hour_ff);
      end
    end
  end

  // weekday: a written value is kept only when it is one-hot
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      week_ff <= RST_WEEK;
    end else if (wr_i && addr_i == ADDR_WEEK) begin
      if ((wr_data_i & MASK_WEEK) != RST_ZERO &&
          ((wr_data_i & MASK_WEEK) & ((wr_data_i & MASK_WEEK) - 8'h01)) == RST_ZERO) begin
        week_ff <= wr_data_i & MASK_WEEK;
      end
    end else if (day_tick) begin
      week_ff <= {1'b0, week_ff[5:0], week_ff[6]};
    end
  end

  // date, month, year
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      day_ff <= RST_DAY;
      month_ff <= RST_MONTH;
      year_ff <= RST_ZERO;
    end else begin
      if (wr_i && addr_i == ADDR_DAY) begin
        day_ff <= wr_data_i & MASK_HOUR;
      end else if (day_tick) begin
        day_ff <= month_tick ? RST_DAY : bcd_inc(day_ff);
      end
      if (wr_i && addr_i == ADDR_MONTH) begin
        month_ff <= wr_data_i & MASK_MONTH;
      end else if (month_tick) begin
        month_ff <= year_tick ? RST_MONTH : bcd_inc(month_ff);
      end
      if (wr_i && addr_i == ADDR_YEAR) begin
        year_ff <= wr_data_i;
      end else if (year_tick) begin
        year_ff <= (year_ff == 8'h99) ? RST_ZERO : bcd_inc(year_ff);
      end
    end
  end

  // alarm, preset and control registers
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      al_min_ff <= RST_ZERO;
      al_hour_ff <= RST_ZERO;
      al_wkdy_ff <= RST_ZERO;
      preset_lo_ff <= RST_ZERO;
      preset_hi_ff <= RST_ZERO;
      config_ff <= RST_ZERO;
      ien_stop_ff <= RST_ZERO;
    end else if (wr_i) begin
      case (addr_i)
        ADDR_AL_MIN: al_min_ff <= wr_data_i;
        ADDR_AL_HOUR: al_hour_ff <= wr_data_i & MASK_AL_HOUR;
        ADDR_AL_WKDY: al_wkdy_ff <= wr_data_i;
        ADDR_PRESET_LO: preset_lo_ff <= wr_data_i;
        ADDR_PRESET_HI: preset_hi_ff <= wr_data_i & MASK_PRESET_HI;
        ADDR_CONFIG: config_ff <= wr_data_i & MASK_CONFIG;
        ADDR_IEN_STOP: ien_stop_ff <= wr_data_i & MASK_IEN_STOP;
        default: ; // time, date and flag addresses are handled by their own processes, 4'hF by none
      endcase
    end
  end

  // alarm compare; checked once per minute so a setting equal to now fires next time
  always_comb begin
    if (config_ff[CFG_TARGET_BIT]) begin
      target_match = (al_wkdy_ff & MASK_HOUR) == day_ff;
    end else begin
      target_match = (al_wkdy_ff & week_ff & MASK_WEEK) != RST_ZERO;
    end
    min_match = al_min_ff[ALARM_IGNORE_BIT] || ((al_min_ff & MASK_SEC) == min_ff);
    hour_match = al_hour_ff[ALARM_IGNORE_BIT] || ((al_hour_ff & MASK_HOUR) == hour_ff);
    alm_match = min_match && hour_match &&
                (al_wkdy_ff[ALARM_IGNORE_BIT] || target_match);
  end

  // alarm delay: wait a fixed number of crystal periods after the minute changes
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      alm_state_ff <= ALM_IDLE;
      alm_dly_ff <= '0;
    end else begin
      case (alm_state_ff)
        ALM_IDLE: begin
          alm_dly_ff <= '0;
          if (min_tick) begin
            alm_state_ff <= ALM_WAIT;
          end
        end
        ALM_WAIT: begin
          if (alm_fire) begin
            alm_state_ff <= ALM_IDLE;
          end else if (xtal_tick && !halt) begin
            alm_dly_ff <= alm_dly_ff + 4'h1;
          end
        end
        default: alm_state_ff <= ALM_IDLE;
      endcase
    end
  end

  assign alm_fire = (alm_state_ff == ALM_WAIT) && xtal_tick && !halt &&
                    (alm_dly_ff == 4'(ALARM_DELAY_XTAL - 1));

  // cycle timer start on a write that raises the run bit
  assign start_pulse = wr_config && wr_data_i[CFG_RUN_BIT] && !config_ff[CFG_RUN_BIT];

  cafct_cycle_timer #(
    .PRESET_W(12)
  ) u_cycle_timer (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .tick_4096_i(tick_4096),
    .tick_64_i(tick_64),
    .tick_1_i(tick_1),
    .tick_min_i(min_tick),
    .clk_sel_i(config_ff[CFG_CLKSEL_LSB +: 2]),
    .run_i(config_ff[CFG_RUN_BIT]),
    .start_i(start_pulse),
    .preset_i({preset_hi_ff[3:0], preset_lo_ff}),
    .expire_o(cycle_expire)
  );

  // event sources; halted dividers give no second or minute ticks
  assign update_set = config_ff[CFG_CADENCE_BIT] ? min_tick : tick_1;
  assign cycle_set = cycle_expire && ien_stop_ff[CYCLE_BIT];
  assign alarm_set = alm_fire && alm_match && ien_stop_ff[ALARM_BIT] && !halt;
  assign set_vec = {2'h0, update_set, cycle_set, alarm_set, 3'h0};

  // sticky flags: zero written clears, one written is ignored, a set wins over a clear
  always_comb begin
    nxt_flags = flags_ff;
    if (wr_flags) begin
      nxt_flags = flags_ff & (wr_data_i | ~MASK_FLAGS);
    end
    nxt_flags = nxt_flags | set_vec;
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      flags_ff <= RST_ZERO;
    end else begin
      flags_ff <= nxt_flags & MASK_FLAGS;
    end
  end

  // interrupt request: any flag whose enable is set
  assign irq_o = |(flags_ff & ien_stop_ff & MASK_FLAGS);

  // read port: answer stands the cycle after the strobe, zero for unmapped addresses
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rd_data_ff <= RST_ZERO;
    end else if (rd_i) begin
      case (addr_i)
        ADDR_SEC: rd_data_ff <= sec_ff;
        ADDR_MIN: rd_data_ff <= min_ff;
        ADDR_HOUR: rd_data_ff <= hour_ff;
        ADDR_WEEK: rd_data_ff <= week_ff;
        ADDR_DAY: rd_data_ff <= day_ff;
        ADDR_MONTH: rd_data_ff <= month_ff;
        ADDR_YEAR: rd_data_ff <= year_ff;
        ADDR_AL_MIN: rd_data_ff <= al_min_ff;
        ADDR_AL_HOUR: rd_data_ff <= al_hour_ff;
        ADDR_AL_WKDY: rd_data_ff <= al_wkdy_ff;
        ADDR_PRESET_LO: rd_data_ff <= preset_lo_ff;
        ADDR_PRESET_HI: rd_data_ff <= preset_hi_ff;
        ADDR_CONFIG: rd_data_ff <= config_ff;
        ADDR_FLAGS: rd_data_ff <= flags_ff;
        ADDR_IEN_STOP: rd_data_ff <= ien_stop_ff;
        default: rd_data_ff <= RST_ZERO;
      endcase
    end else begin
      rd_data_ff <= RST_ZERO;
    end
  end

  assign rd_data_o = rd_data_ff;

  // checks
  AST_WEEK_ROTATE: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    day_tick && !wr_i |=> week_ff == {1'b0, $past(week_ff[5:0]), $past(week_ff[6])})
    else $error("weekday did not rotate");
  AST_DAY_WRAP: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    month_tick && !wr_i |=> day_ff == 8'h01)
    else $error("date did not wrap to first");
  AST_MONTH_WRAP: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    year_tick && !wr_i |=> month_ff == 8'h01)
    else $error("month did not wrap to first");
  AST_YEAR_WRAP: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    year_tick && !wr_i && year_ff == 8'h99 |=> year_ff == 8'h00)
    else $error("year did not wrap");
  AST_LEAP_FEB: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    day_tick && !wr_i && month_ff == 8'h02 && day_ff == 8'h28 && year_ff == 8'h24
    |=> day_ff == 8'h29)
    else $error("leap February skipped the 29th");
  AST_ALARM_DELAY: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    $rose(flags_ff[ALARM_BIT]) |-> $past(alm_dly_ff) == 4'h7 && $past(alm_match))
    else $error("alarm flag not at end of delay");
  AST_FLAG_STICKY: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    flags_ff[UPDATE_BIT] && !(wr_flags && !wr_data_i[UPDATE_BIT]) |=> flags_ff[UPDATE_BIT])
    else $error("update flag dropped without a clear");
  AST_SET_WINS: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    wr_flags && cycle_set |=> flags_ff[CYCLE_BIT])
    else $error("cycle event lost to a clear");
  AST_CYCLE_GATE: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    $rose(flags_ff[CYCLE_BIT]) |-> $past(ien_stop_ff[CYCLE_BIT]))
    else $error("cycle flag set while disabled");
  AST_HALT_QUIET: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    halt |-> !tick_1 && !alarm_set)
    else $error("event while halted");
  AST_IRQ: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    irq_o == ((flags_ff[ALARM_BIT] && ien_stop_ff[ALARM_BIT]) ||
              (flags_ff[CYCLE_BIT] && ien_stop_ff[CYCLE_BIT]) ||
              (flags_ff[UPDATE_BIT] && ien_stop_ff[UPDATE_BIT])))
    else $error("interrupt does not follow flags");

  COV_ALARM: cover property (@(posedge clock_i) disable iff (sys_rst_i)
    $rose(flags_ff[ALARM_BIT]));
  COV_CYCLE: cover property (@(posedge clock_i) disable iff (sys_rst_i)
    $rose(flags_ff[CYCLE_BIT]));
  COV_MONTH_END: cover property (@(posedge clock_i) disable iff (sys_rst_i) month_tick);
  COV_CLEAR: cover property (@(posedge clock_i) disable iff (sys_rst_i)
    flags_ff[UPDATE_BIT] && wr_flags ##1 !flags_ff[UPDATE_BIT]);

endmodule

// [tb/tb_top.sv]
// self-checking bench for the calendar block: registers, flags and cycle timer
module tb_top
  import cafct_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // stimulus and observed signals
  logic clock_i = 1'b0; // 40 MHz system clock
  logic sys_rst_i = 1'b1; // held high at start
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wr_data_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rd_data_o; // registered read data
  logic irq_o; // interrupt request
  int num_errors = 0; // mismatches seen
  int n_compared = 0; // comparisons made
  int seed = 36498; // fixed seed keeps runs repeatable
  int cycles = 0; // watchdog count
  logic [7:0] rdv; // last value read
  logic [7:0] rnd; // random write data
  logic got; // irq seen during a wait
  // writable registers and their implemented bits
  logic [3:0] ra [7] = '{ADDR_AL_MIN, ADDR_AL_HOUR, ADDR_AL_WKDY, ADDR_PRESET_LO,
    ADDR_PRESET_HI, ADDR_CONFIG, ADDR_IEN_STOP};
  logic [7:0] rm [7] = '{8'hFF, MASK_AL_HOUR, 8'hFF, 8'hFF, MASK_PRESET_HI, MASK_CONFIG,
    MASK_IEN_STOP};

  // crystal model ticks every clock, so one second takes 32768 clocks and the carries are reached
  cafct_top #(.XTAL_STEP(SYS_CLK_HZ)) i_dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .irq_o(irq_o));

  // clock, half period 12.5 ns
  always #12.5 clock_i = ~clock_i;

  // watchdog: expiries of about 4096 clocks, two long waits and one second of 32768 clocks
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      num_errors = num_errors + 1;
      final_report();
    end
  end

  // compare and count
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wr_data_i <= d;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask

  // one-cycle read strobe, data sampled in the following cycle only
  task automatic rd(input logic [3:0] a);
    @(posedge clock_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 rdv = rd_data_o;
  endtask

  // bounded wait for the interrupt line
  task automatic wait_irq(output logic seen);
    seen = 1'b0;
    for (int i = 0; i < 40000 && !seen; i++) begin
      @(posedge clock_i);
      #1 seen = (irq_o === 1'b1);
    end
  endtask

  // counts, verdict and end of run
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    // reset values
    rd(ADDR_WEEK);
    check("weekday", rdv, RST_WEEK);
    rd(ADDR_DAY);
    check("date", rdv, RST_DAY);
    rd(ADDR_MONTH);
    check("month", rdv, RST_MONTH);
    rd(ADDR_YEAR);
    check("year", rdv, RST_ZERO);
    rd(ADDR_FLAGS);
    check("flags", rdv, RST_ZERO);
    // unmapped index reads zero, writes ignored
    wr(4'hF, 8'hFF);
    rd(4'hF);
    check("unmapped", rdv, 8'h00);
    // weekday keeps one bit only, a two-bit write is refused
    wr(ADDR_WEEK, 8'h08);
    wr(ADDR_WEEK, 8'h09);
    rd(ADDR_WEEK);
    check("weekday", rdv, 8'h08);
    $display("test reset and weekday done");
    // random data through the alarm, preset, config and enable registers, reserved bits read zero
    for (int n = 0; n < 8; n++) begin
      for (int k = 0; k < 7; k++) begin
        rnd = 8'($random(seed));
        wr(ra[k], rnd);
        rd(ra[k]);
        check("reg rw", rdv, rnd & rm[k]);
      end
    end
    $display("test register access done");
    // fastest source, preset of 512, cycle interrupt enabled
    wr(ADDR_CONFIG, 8'h00);
    wr(ADDR_PRESET_LO, 8'h00);
    wr(ADDR_PRESET_HI, 8'h02);
    wr(ADDR_IEN_STOP, 8'h10);
    wr(ADDR_FLAGS, 8'h00);
    wr(ADDR_CONFIG, 8'h10);
    wait_irq(got);
    check("cycle irq", {7'h00, got}, 8'h01);
    rd(ADDR_FLAGS);
    check("flags", rdv, 8'h10);
    wr(ADDR_FLAGS, 8'h38);
    rd(ADDR_FLAGS);
    check("flags w1", rdv, 8'h10);
    wr(ADDR_FLAGS, 8'h28);
    rd(ADDR_FLAGS);
    check("flags clr", rdv, 8'h00);
    check("irq clr", {7'h00, irq_o}, 8'h00);
    // reload gives a second expiry
    wait_irq(got);
    check("reload irq", {7'h00, got}, 8'h01);
    $display("test cycle timer done");
    // enable low: no cycle flag even across an expiry
    wr(ADDR_IEN_STOP, 8'h00);
    wr(ADDR_FLAGS, 8'h00);
    repeat (6000) @(posedge clock_i);
    rd(ADDR_FLAGS);
    check("no cycle flag", rdv, 8'h00);
    // halt holds the dividers, then resumes
    wr(ADDR_IEN_STOP, 8'h11);
    wr(ADDR_FLAGS, 8'h00);
    repeat (6000) @(posedge clock_i);
    rd(ADDR_FLAGS);
    check("halted flag", rdv, 8'h00);
    wr(ADDR_IEN_STOP, 8'h10);
    wait_irq(got);
    check("resume irq", {7'h00, got}, 8'h01);
    $display("test enable and halt done");
    // last second of the century, minute cadence, daily alarm at 00:00
    wr(ADDR_IEN_STOP, 8'h28);
    wr(ADDR_CONFIG, 8'h20);
    wr(ADDR_AL_MIN, 8'h00);
    wr(ADDR_AL_HOUR, 8'h00);
    wr(ADDR_AL_WKDY, 8'h80);
    wr(ADDR_SEC, 8'h59);
    wr(ADDR_MIN, 8'h59);
    wr(ADDR_HOUR, 8'h23);
    wr(ADDR_DAY, 8'h31);
    wr(ADDR_MONTH, 8'h12);
    wr(ADDR_YEAR, 8'h99);
    wr(ADDR_FLAGS, 8'h00);
    wait_irq(got);
    check("update irq", {7'h00, got}, 8'h01);
    rd(ADDR_FLAGS);
    check("alarm early", rdv, 8'h20);
    repeat (16) @(posedge clock_i);
    rd(ADDR_FLAGS);
    check("update and alarm", rdv, 8'h28);
    rd(ADDR_HOUR);
    check("hour", rdv, 8'h00);
    rd(ADDR_WEEK);
    check("weekday", rdv, 8'h10);
    rd(ADDR_DAY);
    check("date", rdv, 8'h01);
    rd(ADDR_MONTH);
    check("month", rdv, 8'h01);
    rd(ADDR_YEAR);
    check("year", rdv, 8'h00);
    $display("test calendar rollover done");
    final_report();
  end
endmodule
